/* File: pkg/lsh_pkg.sv */
/*
 * Constants, register map and state type for the light sensor host
 * interface. Assumes a 250 MHz core clock; all times are in ns.
 */
package lsh_pkg;
  // ==========================================================
  // Register indices (low nibble of the command byte)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_THLO_L = 4'h2;
  localparam logic [3:0] REG_THLO_H = 4'h3;
  localparam logic [3:0] REG_THHI_L = 4'h4;
  localparam logic [3:0] REG_THHI_H = 4'h5;
  localparam logic [3:0] REG_INTC   = 4'h6;
  localparam logic [3:0] REG_ID     = 4'hA;
  localparam logic [3:0] REG_CH0L   = 4'hC;
  localparam logic [3:0] REG_CH0H   = 4'hD;
  localparam logic [3:0] REG_CH1L   = 4'hE;
  localparam logic [3:0] REG_CH1H   = 4'hF;
  // ==========================================================
  // Reset values and field positions
  localparam logic [1:0] CTRL_RST   = 2'h0;
  localparam logic [1:0] PWR_ON     = 2'h3;
  localparam logic [7:0] TIMING_RST = 8'h02;
  localparam logic [5:0] INTC_RST   = 6'h00;
  localparam logic [7:0] ID_VAL     = 8'h50; // Arbitrary value.
  localparam int CMD_BIT  = 7;
  localparam int CLR_BIT  = 6;
  localparam int WORD_BIT = 5;
  localparam int GAIN_BIT = 4;
  localparam int MAN_BIT  = 3;
  localparam logic [1:0] INTEG_MANUAL = 2'h3;
  localparam logic [1:0] STY_OFF   = 2'h0;
  localparam logic [1:0] STY_LEVEL = 2'h1;
  localparam logic [1:0] STY_TEST  = 2'h3;
  // ==========================================================
  // Bus addresses
  localparam logic [6:0] ADDR_LO  = 7'h29;
  localparam logic [6:0] ADDR_MID = 7'h39;
  localparam logic [6:0] ADDR_HI  = 7'h49;
  localparam logic [6:0] ADDR_ARA = 7'h0C;
  // ==========================================================
  // Integration times
  localparam int CLK_NS    = 4;
  localparam int T2_NS     = 402000000;
  localparam int T1_NS     = 101000000;
  localparam int T0_NS     = 13700000;
  localparam int CYC_T2    = T2_NS / CLK_NS;
  localparam int CYC_T1    = T1_NS / CLK_NS;
  localparam int CYC_T0    = T0_NS / CLK_NS;
  // ==========================================================
  // Bus slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR   = 3'h2,
    ST_WACK = 3'h6,
    ST_RD   = 3'h7,
    ST_RACK = 3'h5
  } lsh_st_e;
endpackage

/* File: design/lsh_conv.sv */
/*
 * Integration sequencer: free-running timed conversions or manual
 * integration, latching both channels together at each end.
 * Assumes the analog counts are stable on the core clock.
 */
`timescale 1ns/100ps
module lsh_conv #(
  parameter int P_CYC2 = lsh_pkg::CYC_T2,
  parameter int P_CYC1 = lsh_pkg::CYC_T1,
  parameter int P_CYC0 = lsh_pkg::CYC_T0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        power_i,
  input  wire logic [1:0]  integ_i,
  input  wire logic        manual_i,
  input  wire logic [15:0] adc_ch0_i,
  input  wire logic [15:0] adc_ch1_i,
  output logic      [15:0] ch0_o,
  output logic      [15:0] ch1_o,
  output logic             done_o,
  output logic             busy_o
);
  logic [31:0] cnt_q;
  logic [31:0] lim;
  logic        man_mode;
  logic        man_run;
  logic        auto_end;
  logic        man_end;
  logic        man_q;

  always_comb begin
    case (integ_i)
      2'h2:    lim = 32'(P_CYC2 - 1);
      2'h1:    lim = 32'(P_CYC1 - 1);
      default: lim = 32'(P_CYC0 - 1);
    endcase
  end

  assign man_mode = power_i && (integ_i == lsh_pkg::INTEG_MANUAL);
  assign man_run  = man_mode && manual_i;
  assign auto_end = power_i && !man_mode && (cnt_q >= lim);
  // manual stop
  // Only a run started in manual mode may end with a latch; leaving auto
  // mode drops the partial integration instead of publishing it.
  assign man_end  = man_q && man_mode && !manual_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
    end else if (!power_i || man_mode || auto_end) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      man_q  <= 1'b0;
    end else begin
      busy_o <= man_mode ? man_run : power_i;
      man_q  <= man_run;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch0_o  <= 16'h0000;
      ch1_o  <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= auto_end || man_end;
      if (auto_end || man_end) begin
        ch0_o <= adc_ch0_i;
        ch1_o <= adc_ch1_i;
      end
    end
  end
endmodule

/* File: design/lsh_host_if.sv */
/*
 * Light sensor host interface: two-wire bus slave, register file,
 * shadowed result readout and threshold/persistence interrupt.
 * Assumes scl, sda and the address strap arrive asynchronously and
 * that the bus wire is resolved outside from sda_oe_n_o.
 */
`timescale 1ns/100ps
module lsh_host_if #(
  parameter int P_CYC2 = lsh_pkg::CYC_T2,
  parameter int P_CYC1 = lsh_pkg::CYC_T1,
  parameter int P_CYC0 = lsh_pkg::CYC_T0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [1:0]  addr_sel_i,
  input  wire logic [15:0] adc_ch0_i,
  input  wire logic [15:0] adc_ch1_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             int_n_o,
  output logic             gain_hi_o,
  output logic             integ_o
);
  // ==========================================================
  // Synchronisers and bus events
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] sel1_q;
  logic [1:0] sel2_q;
  logic scl_r, scl_f, start_w, stop_w, sda_w;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s  <= 3'h7;
      sda_s  <= 3'h7;
      sel1_q <= 2'h1;
      sel2_q <= 2'h1;
    end else begin
      scl_s  <= {scl_s[1:0], scl_i};
      sda_s  <= {sda_s[1:0], sda_i};
      sel1_q <= addr_sel_i;
      sel2_q <= sel1_q;
    end
  end

  assign sda_w   = sda_s[1];
  assign scl_r   = scl_s[1] && !scl_s[2];
  assign scl_f   = !scl_s[1] && scl_s[2];
  assign start_w = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop_w  = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];

  // ==========================================================
  // Registers and conversion
  logic [1:0]  ctrl_q;
  logic [7:0]  tim_q;
  logic [15:0] thlo_q;
  logic [15:0] thhi_q;
  logic [5:0]  intc_q;
  logic [7:0]  sh0_q;
  logic [7:0]  sh1_q;
  logic [3:0]  pcnt_q;
  logic        irq_q;
  logic [15:0] ch0_w;
  logic [15:0] ch1_w;
  logic        done_w;
  logic        busy_w;
  logic        pwr;
  logic [1:0]  style;
  logic [6:0]  own;

  lsh_conv #(
    .P_CYC2 (P_CYC2),
    .P_CYC1 (P_CYC1),
    .P_CYC0 (P_CYC0)
  ) u_conv (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .power_i   (pwr),
    .integ_i   (tim_q[1:0]),
    .manual_i  (tim_q[lsh_pkg::MAN_BIT]),
    .adc_ch0_i (adc_ch0_i),
    .adc_ch1_i (adc_ch1_i),
    .ch0_o     (ch0_w),
    .ch1_o     (ch1_w),
    .done_o    (done_w),
    .busy_o    (busy_w)
  );

  assign pwr   = (ctrl_q == lsh_pkg::PWR_ON);
  assign style = intc_q[5:4];

  always_comb begin
    case (sel2_q)
      2'h0:    own = lsh_pkg::ADDR_LO;
      2'h1:    own = lsh_pkg::ADDR_MID;
      default: own = lsh_pkg::ADDR_HI;
    endcase
  end

  // ==========================================================
  // Bus slave
  lsh_pkg::lsh_st_e st_q;
  logic [2:0] bitc_q;
  logic [7:0] sh_q;
  logic [3:0] ptr_q;
  logic       rw_q, ara_q, word_q, first_q, ackon_q, ack_q, pull_q;
  logic [7:0] byte_w;
  logic [7:0] rd_mux;
  logic [7:0] tx_w;
  logic       match_w, ara_hit, wr_fire, cmd_fire, load_fire;
  logic       ara_won, byte_end;

  assign byte_w   = {sh_q[6:0], sda_w};
  assign byte_end = scl_r && (bitc_q == 3'h7);
  assign match_w  = (sh_q[6:0] == own);
  assign ara_hit  = (sh_q[6:0] == lsh_pkg::ADDR_ARA) && sda_w
                    && irq_q && style[1];
  assign wr_fire  = (st_q == lsh_pkg::ST_WR) && byte_end && !first_q;
  assign cmd_fire = (st_q == lsh_pkg::ST_WR) && byte_end && first_q
                    && byte_w[lsh_pkg::CMD_BIT];
  assign load_fire = scl_f && (((st_q == lsh_pkg::ST_AACK) && ackon_q
                    && rw_q) || ((st_q == lsh_pkg::ST_RACK) && ack_q));
  assign ara_won  = (st_q == lsh_pkg::ST_RD) && scl_f
                    && (bitc_q == 3'h7) && ara_q;
  assign tx_w     = ara_q ? {own, 1'b0} : rd_mux;

  always_comb begin
    case (ptr_q)
      lsh_pkg::REG_CTRL:   rd_mux = {6'h00, ctrl_q};
      lsh_pkg::REG_TIMING: rd_mux = tim_q;
      lsh_pkg::REG_THLO_L: rd_mux = thlo_q[7:0];
      lsh_pkg::REG_THLO_H: rd_mux = thlo_q[15:8];
      lsh_pkg::REG_THHI_L: rd_mux = thhi_q[7:0];
      lsh_pkg::REG_THHI_H: rd_mux = thhi_q[15:8];
      lsh_pkg::REG_INTC:   rd_mux = {2'h0, intc_q};
      lsh_pkg::REG_ID:     rd_mux = lsh_pkg::ID_VAL;
      lsh_pkg::REG_CH0L:   rd_mux = ch0_w[7:0];
      lsh_pkg::REG_CH0H:   rd_mux = sh0_q;
      lsh_pkg::REG_CH1L:   rd_mux = ch1_w[7:0];
      lsh_pkg::REG_CH1H:   rd_mux = sh1_q;
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= lsh_pkg::ST_IDLE;
      bitc_q  <= 3'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 4'h0;
      rw_q    <= 1'b0;
      ara_q   <= 1'b0;
      word_q  <= 1'b0;
      first_q <= 1'b0;
      ackon_q <= 1'b0;
      ack_q   <= 1'b0;
      pull_q  <= 1'b0;
    end else if (start_w) begin
      st_q    <= lsh_pkg::ST_ADDR;
      bitc_q  <= 3'h0;
      ackon_q <= 1'b0;
      pull_q  <= 1'b0;
    end else if (stop_w) begin
      st_q   <= lsh_pkg::ST_IDLE;
      pull_q <= 1'b0;
    end else begin
      case (st_q)
        lsh_pkg::ST_ADDR, lsh_pkg::ST_WR: begin
          if (scl_r) begin
            sh_q   <= byte_w;
            bitc_q <= bitc_q + 3'h1;
          end
          if (byte_end && st_q == lsh_pkg::ST_ADDR) begin
            rw_q  <= sda_w;
            ara_q <= ara_hit;
            st_q  <= (match_w || ara_hit) ? lsh_pkg::ST_AACK
                                          : lsh_pkg::ST_IDLE;
          end else if (byte_end) begin
            st_q    <= lsh_pkg::ST_WACK;
            first_q <= 1'b0;
            if (cmd_fire) begin
              ptr_q  <= byte_w[3:0];
              word_q <= byte_w[lsh_pkg::WORD_BIT];
            end else if (!first_q && word_q) begin
              ptr_q <= ptr_q + 4'h1;
            end
          end
        end
        lsh_pkg::ST_AACK, lsh_pkg::ST_WACK: begin
          if (scl_f && !ackon_q) begin
            pull_q  <= 1'b1;
            ackon_q <= 1'b1;
          end else if (scl_f) begin
            ackon_q <= 1'b0;
            bitc_q  <= 3'h0;
            if (load_fire) begin
              sh_q   <= tx_w;
              pull_q <= !tx_w[7];
              st_q   <= lsh_pkg::ST_RD;
            end else begin
              pull_q <= 1'b0;
              st_q   <= lsh_pkg::ST_WR;
              if (st_q == lsh_pkg::ST_AACK) begin
                first_q <= 1'b1;
              end
            end
          end
        end
        lsh_pkg::ST_RD: begin
          if (scl_r && !pull_q && !sda_w) begin
            st_q <= lsh_pkg::ST_IDLE;
          end else if (scl_f && bitc_q == 3'h7) begin
            pull_q <= 1'b0;
            st_q   <= lsh_pkg::ST_RACK;
            if (word_q && !ara_q) begin
              ptr_q <= ptr_q + 4'h1;
            end
          end else if (scl_f) begin
            pull_q <= !sh_q[6];
            sh_q   <= {sh_q[6:0], 1'b0};
            bitc_q <= bitc_q + 3'h1;
          end
        end
        lsh_pkg::ST_RACK: begin
          if (scl_r) begin
            ack_q <= !sda_w;
          end else if (load_fire) begin
            sh_q   <= tx_w;
            pull_q <= !tx_w[7];
            bitc_q <= 3'h0;
            st_q   <= lsh_pkg::ST_RD;
          end else if (scl_f) begin
            st_q <= lsh_pkg::ST_IDLE;
          end
        end
        default: st_q <= lsh_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register writes
  // reset defaults
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= lsh_pkg::CTRL_RST;
      tim_q  <= lsh_pkg::TIMING_RST;
      thlo_q <= 16'h0000;
      thhi_q <= 16'h0000;
      intc_q <= lsh_pkg::INTC_RST;
    end else if (wr_fire) begin
      case (ptr_q)
        lsh_pkg::REG_CTRL:   ctrl_q <= byte_w[1:0];
        lsh_pkg::REG_TIMING: tim_q <= byte_w;
        lsh_pkg::REG_THLO_L: thlo_q[7:0] <= byte_w;
        lsh_pkg::REG_THLO_H: thlo_q[15:8] <= byte_w;
        lsh_pkg::REG_THHI_L: thhi_q[7:0] <= byte_w;
        lsh_pkg::REG_THHI_H: thhi_q[15:8] <= byte_w;
        lsh_pkg::REG_INTC:   intc_q <= byte_w[5:0];
        default:             ctrl_q <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh0_q <= 8'h00;
      sh1_q <= 8'h00;
    end else if (load_fire && !ara_q) begin
      if (ptr_q == lsh_pkg::REG_CH0L) begin
        sh0_q <= ch0_w[15:8];
      end
      if (ptr_q == lsh_pkg::REG_CH1L) begin
        sh1_q <= ch1_w[15:8];
      end
    end
  end

  // ==========================================================
  // Interrupt
  logic       out_w, hit_w, set_w, clr_w, test_w;
  logic [4:0] pnxt;
  assign out_w  = (ch0_w < thlo_q) || (ch0_w > thhi_q);
  assign pnxt   = {1'b0, pcnt_q} + 5'h01;
  assign hit_w  = out_w && (pnxt >= {1'b0, intc_q[3:0]});
  assign test_w = wr_fire && (ptr_q == lsh_pkg::REG_INTC)
                  && (byte_w[5:4] == lsh_pkg::STY_TEST);
  assign set_w  = (done_w && (style != lsh_pkg::STY_OFF)
                  && ((intc_q[3:0] == 4'h0) || hit_w)) || test_w;
  assign clr_w  = (cmd_fire && byte_w[lsh_pkg::CLR_BIT]
                  && style == lsh_pkg::STY_LEVEL) || ara_won;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcnt_q <= 4'h0;
    end else if (done_w) begin
      pcnt_q <= !out_w ? 4'h0 : (pnxt[4] ? 4'hF : pnxt[3:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else if (set_w) begin
      irq_q <= 1'b1;
    end else if (clr_w) begin
      irq_q <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  // output disable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
      int_n_o    <= 1'b1;
      gain_hi_o  <= 1'b0;
      integ_o    <= 1'b0;
    end else begin
      sda_o      <= !pull_q;
      sda_oe_n_o <= !pull_q;
      int_n_o    <= !(irq_q && style != lsh_pkg::STY_OFF);
      gain_hi_o  <= tim_q[lsh_pkg::GAIN_BIT];
      integ_o    <= busy_w;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  pwr_idle_a: assert property (!pwr && !$past(pwr) |-> !done_w)
    else $error("conversion finished while powered down");
  pwr_on_a: assert property (wr_fire && ptr_q == lsh_pkg::REG_CTRL
    && byte_w == 8'h03 && tim_q[1:0] != lsh_pkg::INTEG_MANUAL
    |=> pwr ##2 integ_o)
    else $error("power-up write did not start conversions");
  addr_miss_a: assert property ((st_q == lsh_pkg::ST_ADDR)
    && byte_end && !match_w && !ara_hit |=> st_q == lsh_pkg::ST_IDLE)
    else $error("answered a foreign address");
  shadow_a: assert property (load_fire && !ara_q
    && ptr_q == lsh_pkg::REG_CH0L |=> sh0_q == $past(ch0_w[15:8]))
    else $error("shadow byte not captured");
  every_conv_a: assert property (done_w && intc_q[3:0] == 4'h0
    && style != lsh_pkg::STY_OFF |=> irq_q ##1 !int_n_o)
    else $error("persistence zero did not interrupt");
  irq_hold_a: assert property (irq_q && !clr_w |=> irq_q)
    else $error("interrupt dropped without a clear");
  lvl_clear_a: assert property (clr_w && !set_w |=> !irq_q)
    else $error("level clear ignored");
  test_set_a: assert property (test_w |=> irq_q ##1 !int_n_o)
    else $error("test style did not set interrupt");
  pers_reset_a: assert property (done_w && !out_w |=> pcnt_q == 4'h0)
    else $error("persistence count kept after in-range result");
  irq_off_a: assert property (style == lsh_pkg::STY_OFF |=> int_n_o)
    else $error("disabled interrupt drove the line");

  cover property (wr_fire && ptr_q == lsh_pkg::REG_CTRL);
  cover property (ara_won);
  cover property (load_fire && ptr_q == lsh_pkg::REG_CH0H);
  cover property (irq_q ##1 !irq_q);
endmodule

/* File: sim/lsh_bus_host.sv */
/*
 * Bus host model: start and stop conditions, byte transfers, register
 * writes, reads with a repeated start and the alert response read.
 * Assumes a pulled-up data wire and calls made off the core clock edge.
 */
`timescale 1ns/100ps
module lsh_bus_host (
  output logic      scl_o,
  output logic      sda_oe_n_o,
  input  wire logic sda_i
);
  // Quarter bit time; each scl level lasts four core clocks.
  localparam int Q = 8;

  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // ==========================================================
  // Conditions and bits
  // Data only moves while scl is low, except for start and stop.
  task automatic cond(input logic stop);
    sda_oe_n_o = stop ? 1'b0 : 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_oe_n_o = stop ? 1'b1 : 1'b0;
    #Q;
    scl_o = stop;
    #Q;
  endtask

  task automatic bits(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_n_o = d[i];
      #Q;
      scl_o = 1'b1;
      #Q;
      r[i] = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
    end
  endtask

  // ==========================================================
  // Transactions
  // address, command byte, then data bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input int n, input logic [15:0] d,
                    input logic hold, output logic ok);
    logic [8:0] r;
    cond(1'b0);
    bits({a, 2'b01}, r);
    ok = ~r[0];
    bits({c, 1'b1}, r);
    ok = ok & ~r[0];
    for (int i = 0; i < n; i++) begin
      bits({d[8*i +: 8], 1'b1}, r);
      ok = ok & ~r[0];
    end
    if (!hold)
      cond(1'b1);
  endtask

  // low byte first, last byte refused, then stop
  task automatic rcv(input logic [6:0] a, input int n,
                     output logic [15:0] q, output logic ok);
    logic [8:0] r;
    q = 16'h0000;
    cond(1'b0);
    bits({a, 2'b11}, r);
    ok = ~r[0];
    for (int i = 0; i < n; i++) begin
      bits({8'hFF, i == n - 1}, r);
      q[8*i +: 8] = r[8:1];
    end
    cond(1'b1);
  endtask
endmodule

/* File: sim/lsh_host_if_bench.sv */
/*
 * Self-checking bench for lsh_host_if driven by the bus host model.
 * Assumes shortened integration counts and a pulled-up data wire.
 */
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
    end \
  end

module lsh_host_if_bench;
  // Short counts keep the run small; the conversion waits scale with them.
  localparam int P2 = 2000;
  localparam int P1 = 1000;
  localparam int P0 = 500;
  localparam int LIMIT = 80000;
  logic        clk_i;
  logic        rst_n_i;
  logic        scl;
  logic        host_oe_n;
  logic        dut_sda;
  logic        dut_oe_n;
  wire logic   sda;
  logic [1:0]  addr_sel;
  logic [15:0] adc0;
  logic [15:0] adc1;
  logic        int_n;
  logic        gain_hi;
  logic        integ;
  logic [15:0] v;
  logic        ok;
  logic [16:0] rows [6];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;

  assign sda = host_oe_n & (dut_oe_n | dut_sda);

  lsh_host_if #(
    .P_CYC2 (P2),
    .P_CYC1 (P1),
    .P_CYC0 (P0)
  ) u_dut (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .scl_i      (scl),
    .sda_i      (sda),
    .addr_sel_i (addr_sel),
    .adc_ch0_i  (adc0),
    .adc_ch1_i  (adc1),
    .sda_o      (dut_sda),
    .sda_oe_n_o (dut_oe_n),
    .int_n_o    (int_n),
    .gain_hi_o  (gain_hi),
    .integ_o    (integ)
  );

  lsh_bus_host u_host (
    .scl_o      (scl),
    .sda_oe_n_o (host_oe_n),
    .sda_i      (sda)
  );

  // ==========================================================
  // Clock, timeout and verdict
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // Bus helpers
  task automatic w(input logic [7:0] c, input int k, input logic [15:0] d);
    u_host.wr(lsh_pkg::ADDR_MID, c, k, d, 1'b0, ok);
    `CHK(ok, 1'b1)
    @(negedge clk_i);
  endtask

  task automatic rc(input logic [7:0] c, input int k, input logic [15:0] e);
    u_host.wr(lsh_pkg::ADDR_MID, c, 0, 16'h0000, 1'b1, ok);
    u_host.rcv(lsh_pkg::ADDR_MID, k, v, ok);
    @(negedge clk_i);
    `CHK(v, e)
  endtask

  task automatic wait_low(input int lim);
    n = 0;
    while (int_n !== 1'b0 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    addr_sel = 2'h1;
    adc0 = 16'h1234;
    adc1 = 16'hABCD;
    // Command, data written and read back, expected gain output.
    rows = '{{8'h81, 8'h01, 1'b0}, {8'h81, 8'h00, 1'b0},
             {8'h81, 8'h11, 1'b1}, {8'h81, 8'h02, 1'b0},
             {8'h86, 8'h00, 1'b0}, {8'h80, 8'h03, 1'b0}};
    repeat (5) @(negedge clk_i);
    `CHK(int_n, 1'b1)
    `CHK(integ, 1'b0)
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rc(8'h81, 1, 16'h0002);
    rc(8'h80, 1, 16'h0000);
    rc(8'hAC, 2, 16'h0000);
    // The last row powers the device up with the default timing.
    foreach (rows[i]) begin
      w(rows[i][16:9], 1, {8'h00, rows[i][8:1]});
      `CHK(gain_hi, rows[i][0])
      rc(rows[i][16:9], 1, {8'h00, rows[i][8:1]});
    end
    `CHK(integ, 1'b1)
    repeat (P2 + 100) @(negedge clk_i);
    rc(8'hAC, 2, 16'h1234);
    rc(8'hAE, 2, 16'hABCD);
    rc(8'h8E, 1, 16'h00CD);
    rc(8'h8F, 1, 16'h00AB);
    rc(8'h8C, 1, 16'h0034);
    adc0 = 16'h5678;
    repeat (P2 + 100) @(negedge clk_i);
    rc(8'h8D, 1, 16'h0012);
    rc(8'hAC, 2, 16'h5678);
    w(8'h86, 1, 16'h0010);
    wait_low(P2 + 100);
    `CHK(int_n, 1'b0)
    repeat (100) @(negedge clk_i);
    `CHK(int_n, 1'b0)
    w(8'hC0, 0, 16'h0000);
    `CHK(int_n, 1'b1)
    adc0 = 16'h1800;
    adc1 = 16'hFFFF;
    w(8'hA2, 2, 16'h1000);
    w(8'hA4, 2, 16'h2000);
    w(8'h81, 1, 16'h0001);
    w(8'hC0, 0, 16'h0000);
    // Sync to a conversion end so the persistence count is exact.
    wait_low(P2 + 100);
    `CHK(int_n, 1'b0)
    adc0 = 16'h3000;
    w(8'h86, 1, 16'h0012);
    w(8'hC0, 0, 16'h0000);
    repeat (P1) @(negedge clk_i);
    `CHK(int_n, 1'b1)
    wait_low(P1);
    `CHK(int_n, 1'b0)
    adc0 = 16'h1800;
    w(8'hC0, 0, 16'h0000);
    `CHK(int_n, 1'b1)
    w(8'h86, 1, 16'h0031);
    `CHK(int_n, 1'b0)
    w(8'hC0, 0, 16'h0000);
    `CHK(int_n, 1'b0)
    u_host.rcv(lsh_pkg::ADDR_ARA, 1, v, ok);
    @(negedge clk_i);
    `CHK(ok, 1'b1)
    `CHK(v[7:1], lsh_pkg::ADDR_MID)
    `CHK(int_n, 1'b1)
    repeat (P1 + 100) @(negedge clk_i);
    `CHK(int_n, 1'b1)
    adc0 = 16'h3000;
    w(8'h86, 1, 16'h0000);
    repeat (2 * P1 + 100) @(negedge clk_i);
    `CHK(int_n, 1'b1)
    w(8'h81, 1, 16'h0003);
    `CHK(integ, 1'b0)
    adc0 = 16'h4321;
    repeat (P1 + 100) @(negedge clk_i);
    rc(8'hAC, 2, 16'h3000);
    w(8'h81, 1, 16'h000B);
    `CHK(integ, 1'b1)
    w(8'h81, 1, 16'h0003);
    rc(8'hAC, 2, 16'h4321);
    addr_sel = 2'h0;
    repeat (4) @(negedge clk_i);
    u_host.wr(lsh_pkg::ADDR_MID, 8'h81, 1, 16'h0002, 1'b0, ok);
    `CHK(ok, 1'b0)
    u_host.wr(lsh_pkg::ADDR_LO, 8'h81, 1, 16'h0002, 1'b0, ok);
    `CHK(ok, 1'b1)
    addr_sel = 2'h2;
    repeat (4) @(negedge clk_i);
    u_host.wr(lsh_pkg::ADDR_HI, 8'h81, 1, 16'h0011, 1'b0, ok);
    `CHK(ok, 1'b1)
    @(negedge clk_i);
    `CHK(gain_hi, 1'b1)
    // Reset in mid-run must bring back the defaults and power down.
    rst_n_i = 1'b0;
    @(negedge clk_i);
    `CHK(gain_hi, 1'b0)
    `CHK(integ, 1'b0)
    addr_sel = 2'h1;
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rc(8'h81, 1, 16'h0002);
    rc(8'h80, 1, 16'h0000);
    `CHK(int_n, 1'b1)
    summarize();
  end
endmodule
